/* core/ioc_ctrl.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - ulp lock bit 7 set blocks writes to the ulp register
// - ulp trim bits 4:0 loaded from calibration at startup
// - mid range bits 31:30 loaded at startup, select band
// - mid trim bits 27:16 loaded at startup, temperature and process halves
// - prescaler bits 9:8 divide mid clock by 1, 2, 4 or 8
// - on-demand bit 7 runs enabled source only when requested
// - standby stops source unless run-in-standby bit 6 set
// - enable bit 1 reads 0 off or starting, 1 on or stopping
// - loop bit 9 zero enables quick lock
// - loop bit 8 zero enables chill cycle
// - loop bit 4 drops locks on wake after a stopped clock
// - loop bit 3 freezes fine value after fine lock
// - loop bit 2 selects open or closed loop
// - loop control resets to 0x0080
// - slow output bit 2 gates the 32 kHz output
// - loop enable reads back at once, acts after sync delay
module ioc_ctrl
    import ioc_pkg::*;
#(
    parameter int SYNC_CYCLES  = SYNC_CYC,
    parameter int START_CYCLES = START_CYC
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system
    input  wire logic        write_protect,
    input  wire logic        in_standby,
    input  wire logic        wake_event,
    input  wire ioc_pkg::ioc_trim_value_s trim_value,
    // peripheral clock requests
    input  wire logic        mid_request,
    input  wire logic        loop_request,
    // oscillator inputs
    input  wire logic        mid_osc_clk,
    input  wire logic        slow_osc_clk,
    input  wire logic        loop_fine_locked,
    // oscillator controls
    output ioc_pkg::ioc_mid_s mid_cfg,
    output logic [4:0]       ulp_trim,
    output logic             mid_run,
    output logic             mid_div_clk,
    output logic             loop_run,
    output logic             loop_closed,
    output logic             loop_quick_lock,
    output logic             loop_chill_cycle,
    output logic             loop_drop_locks,
    output logic             loop_freeze_fine,
    output logic             slow_clk_out
);
    import ioc_pkg::*;

    // ==============================
    // registers
    logic [7:0]  ulp_q;
    logic        loaded_q;
    ioc_mid_s    mid_q;
    logic [15:0] fl_q;
    logic [7:0]  slow_q;
    logic        mid_on_q;
    logic [7:0]  mid_cnt_q;
    logic        loop_act_q;
    logic [7:0]  loop_cnt_q;
    logic        loop_stopped_q;
    logic        fine_frozen_q;
    logic [2:0]  div_cnt_q;
    logic        mid_clk_s;
    logic        slow_clk_s;
    logic        mid_clk_q;
    logic        mid_gate_run;
    logic        loop_gate_run;
    logic        wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // true on the last sampled edge of each group of 2^sel edges
    function automatic logic div_due(input logic [2:0] cnt, input logic [1:0] sel);
        logic [2:0] mask;
        mask    = 3'((4'd1 << sel) - 4'd1);
        div_due = (cnt & mask) == 3'd0;
    endfunction : div_due

    // ==============================
    // bus
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr      = psel && penable && pwrite && !write_protect;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= 1'b0;
            ulp_q    <= '0;
        end else if (!loaded_q) begin
            // calibration is copied once, on the first edge after reset
            loaded_q <= 1'b1;
            ulp_q    <= {3'b000, trim_value.ulp_trim};
        end else if (wr && hit(paddr, ULP_OSC_OFFSET) && !ulp_q[ULP_LOCK_BIT]) begin
            ulp_q <= {pwdata[ULP_LOCK_BIT], 2'b00, pwdata[ULP_TRIM_W-1:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_q <= '0;
        end else if (!loaded_q) begin
            mid_q.range    <= trim_value.range;
            mid_q.trim     <= trim_value.mid_trim;
            mid_q.div      <= MID_RESET_LOW[MID_DIV_LSB +: 2];
            mid_q.request_gated_run <= MID_RESET_LOW[REQUEST_GATED_RUN_BIT];
            mid_q.standby  <= MID_RESET_LOW[STANDBY_BIT];
            mid_q.enable   <= MID_RESET_LOW[ENABLE_BIT];
        end else if (wr && hit(paddr, MID_OSC_OFFSET)) begin
            mid_q.range    <= pwdata[MID_RANGE_LSB +: 2];
            mid_q.trim     <= pwdata[MID_TRIM_LSB +: MID_TRIM_W];
            mid_q.div      <= pwdata[MID_DIV_LSB +: 2];
            mid_q.request_gated_run <= pwdata[REQUEST_GATED_RUN_BIT];
            mid_q.standby  <= pwdata[STANDBY_BIT];
            mid_q.enable   <= pwdata[ENABLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_q <= FL_RESET;
        end else if (wr && hit(paddr, FLOOP_OFFSET)) begin
            fl_q <= pwdata[15:0] & FL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_q <= '0;
        end else if (wr && hit(paddr, CTRL_OFFSET)) begin
            slow_q <= {5'b00000, pwdata[SLOW_OUT_BIT], pwdata[SLOW_EN_BIT], 1'b0};
        end
    end

    always_comb begin
        prdata = '0;
        if (psel && !pwrite) begin
            unique case (paddr)
                ULP_OSC_OFFSET: prdata = {24'h00_0000, ulp_q};
                MID_OSC_OFFSET: begin
                    prdata[MID_RANGE_LSB +: 2]          = mid_q.range;
                    prdata[MID_TRIM_LSB +: MID_TRIM_W]  = mid_q.trim;
                    prdata[MID_DIV_LSB +: 2]            = mid_q.div;
                    prdata[REQUEST_GATED_RUN_BIT]                = mid_q.request_gated_run;
                    prdata[STANDBY_BIT]                 = mid_q.standby;
                    prdata[ENABLE_BIT]                  = mid_on_q;
                end
                FLOOP_OFFSET:   prdata = {16'h0000, fl_q};
                STATUS_OFFSET:  prdata = {28'h000_0000, fine_frozen_q, loop_act_q,
                                          mid_run, mid_on_q};
                CTRL_OFFSET:    prdata = {24'h00_0000, slow_q};
                default:        prdata = '0;
            endcase
        end
    end

    // ==============================
    // mid oscillator enable handshake
    // the enable bit shows the settled state until a start or stop is over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_on_q  <= 1'b0;
            mid_cnt_q <= '0;
        end else if (mid_q.enable == mid_on_q) begin
            mid_cnt_q <= '0;
        end else if (mid_cnt_q == 8'(START_CYCLES - 1)) begin
            mid_on_q  <= mid_q.enable;
            mid_cnt_q <= '0;
        end else begin
            mid_cnt_q <= mid_cnt_q + 8'd1;
        end
    end

    ioc_gate u_mid_gate (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (mid_on_q),
        .request_gated_run    (mid_q.request_gated_run),
        .standby_run (mid_q.standby),
        .in_standby  (in_standby),
        .request     (mid_request),
        .run         (mid_gate_run)
    );
    assign mid_run = mid_gate_run;

    // ==============================
    // mid prescaler on sampled oscillator edges
    // both oscillator clocks are asynchronous to pclk
    ioc_sync3 #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({mid_osc_clk, slow_osc_clk}),
        .q       ({mid_clk_s, slow_clk_s})
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_clk_q   <= 1'b0;
            div_cnt_q   <= '0;
            mid_div_clk <= 1'b0;
        end else begin
            mid_clk_q <= mid_clk_s;
            if (!mid_run) begin
                div_cnt_q   <= '0;
                mid_div_clk <= 1'b0;
            end else if (mid_clk_s && !mid_clk_q) begin
                div_cnt_q   <= div_cnt_q + 3'd1;
                mid_div_clk <= div_due(div_cnt_q + 3'd1, mid_q.div);
            end else begin
                // one pclk pulse per divided edge, whatever the ratio
                mid_div_clk <= 1'b0;
            end
        end
    end

    // ==============================
    // loop enable sync delay and controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_act_q <= 1'b0;
            loop_cnt_q <= '0;
        end else if (fl_q[ENABLE_BIT] == loop_act_q) begin
            loop_cnt_q <= '0;
        end else if (loop_cnt_q == 8'(SYNC_CYCLES - 1)) begin
            loop_act_q <= fl_q[ENABLE_BIT];
            loop_cnt_q <= '0;
        end else begin
            loop_cnt_q <= loop_cnt_q + 8'd1;
        end
    end

    ioc_gate u_loop_gate (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (loop_act_q),
        .request_gated_run    (fl_q[REQUEST_GATED_RUN_BIT]),
        .standby_run (fl_q[STANDBY_BIT]),
        .in_standby  (in_standby),
        .request     (loop_request),
        .run         (loop_gate_run)
    );
    assign loop_run = loop_gate_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_stopped_q  <= 1'b0;
            loop_drop_locks <= 1'b0;
        end else begin
            loop_drop_locks <= wake_event && loop_stopped_q && fl_q[FL_DROP_LOCK_ON_WAKE_BIT];
            if (in_standby && !loop_run) begin
                loop_stopped_q <= 1'b1;
            end else if (wake_event) begin
                loop_stopped_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_frozen_q <= 1'b0;
        end else if (!fl_q[FL_STABLE_BIT] || !loop_act_q || loop_drop_locks) begin
            fine_frozen_q <= 1'b0;
        end else if (loop_fine_locked) begin
            fine_frozen_q <= 1'b1;
        end
    end

    assign loop_freeze_fine = fine_frozen_q;
    assign loop_quick_lock  = !fl_q[FL_QLOFF_BIT];
    assign loop_chill_cycle = !fl_q[FL_CCOFF_BIT];
    assign loop_closed      = fl_q[FL_MODE_BIT];
    assign mid_cfg          = mid_q;
    assign ulp_trim         = ulp_q[ULP_TRIM_W-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_clk_out <= 1'b0;
        end else begin
            // gated by both control bits and the sampled clock
            slow_clk_out <= slow_q[SLOW_OUT_BIT] && slow_q[SLOW_EN_BIT] && slow_clk_s;
        end
    end
endmodule : ioc_ctrl
`default_nettype wire

/* core/ioc_pkg.sv */
package ioc_pkg;
    // ==============================
    // register map
    localparam logic [7:0]  ULP_OSC_OFFSET      = 8'h1c;
    localparam logic [7:0]  MID_OSC_OFFSET      = 8'h20;
    localparam logic [7:0]  FLOOP_OFFSET        = 8'h24;
    localparam logic [7:0]  STATUS_OFFSET       = 8'h38;
    localparam logic [7:0]  CTRL_OFFSET         = 8'h3c;
    // ==============================
    // ulp oscillator fields
    localparam int          ULP_LOCK_BIT        = 7;
    localparam int          ULP_TRIM_LSB        = 0;
    localparam int          ULP_TRIM_W          = 5;
    // ==============================
    // mid oscillator fields
    localparam int          MID_RANGE_LSB       = 30;
    localparam int          MID_TRIM_LSB        = 16;
    localparam int          MID_TRIM_W          = 12;
    localparam int          MID_DIV_LSB         = 8;
    localparam int          REQUEST_GATED_RUN_BIT        = 7;
    localparam int          STANDBY_BIT         = 6;
    localparam int          ENABLE_BIT          = 1;
    localparam logic [31:0] MID_RESET_LOW       = 32'h0000_0382;
    // ==============================
    // loop and slow oscillator fields
    localparam int          FL_QLOFF_BIT        = 9;
    localparam int          FL_CCOFF_BIT        = 8;
    localparam int          FL_DROP_LOCK_ON_WAKE_BIT         = 4;
    localparam int          FL_STABLE_BIT       = 3;
    localparam int          FL_MODE_BIT         = 2;
    localparam logic [15:0] FL_RESET            = 16'h0080;
    localparam logic [15:0] FL_MASK             = 16'h03de;
    localparam int          SLOW_OUT_BIT        = 2;
    localparam int          SLOW_EN_BIT         = 1;
    // ==============================
    // timing
    localparam int          CLK_MHZ             = 125;
    localparam int          SYNC_NS             = 48;
    localparam int          SYNC_CYC            = (SYNC_NS * CLK_MHZ + 999) / 1000;
    localparam int          START_NS            = 200;
    localparam int          START_CYC           = (START_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [1:0]  range;
        logic [11:0] trim;
        logic [1:0]  div;
        logic        request_gated_run;
        logic        standby;
        logic        enable;
    } ioc_mid_s;

    typedef struct packed {
        logic [1:0]  range;
        logic [11:0] mid_trim;
        logic [4:0]  ulp_trim;
    } ioc_trim_value_s;
endpackage : ioc_pkg

/* core/ioc_gate.sv */
`timescale 1ns/1ns
`default_nettype none
module ioc_gate (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // controls
    input  wire logic enable,
    input  wire logic request_gated_run,
    input  wire logic standby_run,
    input  wire logic in_standby,
    input  wire logic request,
    // result
    output logic      run
);
    // oscillator runs when enabled, gated by demand and standby
    always_comb begin
        run = enable && (!request_gated_run || request) && (!in_standby || standby_run);
    end
endmodule : ioc_gate
`default_nettype wire

/* core/ioc_sync3.sv */
`timescale 1ns/1ns
`default_nettype none
module ioc_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule : ioc_sync3
`default_nettype wire

/* verification/ioc_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ioc_ctrl_sva
    import ioc_pkg::*;
#(
    parameter int SYNC_CYCLES  = SYNC_CYC,
    parameter int START_CYCLES = START_CYC
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    // system
    input wire logic              write_protect,
    input wire logic              in_standby,
    input wire logic              wake_event,
    input wire logic              mid_request,
    input wire logic              loop_fine_locked,
    // controls
    input wire ioc_pkg::ioc_mid_s mid_cfg,
    input wire logic [4:0]        ulp_trim,
    input wire logic              mid_run,
    input wire logic              loop_run,
    input wire logic              loop_closed,
    input wire logic              loop_quick_lock,
    input wire logic              loop_chill_cycle,
    input wire logic              loop_drop_locks,
    input wire logic              loop_freeze_fine
);
    // ==============================
    // helpers
    localparam int LOOP_MAX = SYNC_CYCLES + 2;
    logic wr_ok;
    logic lock_q;
    assign wr_ok = psel && penable && pwrite && pready && !write_protect;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
        end else if (wr_ok && paddr == ULP_OSC_OFFSET && pwdata[ULP_LOCK_BIT]) begin
            lock_q <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_loop_wr;
        wr_ok && paddr == FLOOP_OFFSET;
    endsequence
    sequence s_loop_start;
        wr_ok && paddr == FLOOP_OFFSET && pwdata[1] && !pwdata[7] && !in_standby && !loop_run;
    endsequence
    // ==============================
    // assertions
    a_quick_lock_map: assert property (s_loop_wr |=> loop_quick_lock == !$past(pwdata[9]))
        else $error("quick lock does not follow bit 9");
    a_chill_cycle_map: assert property (s_loop_wr |=> loop_chill_cycle == !$past(pwdata[8]))
        else $error("chill cycle does not follow bit 8");
    a_loop_mode_map: assert property (s_loop_wr |=> loop_closed == $past(pwdata[2]))
        else $error("loop mode does not follow bit 2");
    a_ulp_trim_write: assert property (wr_ok && paddr == ULP_OSC_OFFSET && !lock_q
        |=> ulp_trim == $past(pwdata[4:0]))
        else $error("ulp trim not written");
    a_ulp_lock_hold: assert property (lock_q |=> $stable(ulp_trim))
        else $error("ulp trim changed while locked");
    a_protect_hold: assert property (psel && penable && pwrite && write_protect
        |=> $stable(mid_cfg[18:1]) && $stable(ulp_trim))
        else $error("write taken under protection");
    a_div_write: assert property (wr_ok && paddr == MID_OSC_OFFSET
        |=> mid_cfg.div == $past(pwdata[9:8]))
        else $error("prescaler field not written");
    a_mid_gating: assert property (mid_run
        |-> (!mid_cfg.request_gated_run || mid_request) && (!in_standby || mid_cfg.standby))
        else $error("mid oscillator runs when gated off");
    a_loop_sync: assert property (s_loop_start |=> !loop_run ##[1:LOOP_MAX] loop_run)
        else $error("loop enable not delayed or never taken");
    a_drop_cause: assert property ($rose(loop_drop_locks) |-> $past(wake_event))
        else $error("locks dropped without wake");
    a_freeze_cause: assert property ($rose(loop_freeze_fine) |-> $past(loop_fine_locked))
        else $error("fine value frozen without fine lock");
endmodule : ioc_ctrl_sva

bind ioc_ctrl ioc_ctrl_sva #(.SYNC_CYCLES(SYNC_CYCLES), .START_CYCLES(START_CYCLES)) u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .write_protect,
    .in_standby, .wake_event, .mid_request, .loop_fine_locked, .mid_cfg, .ulp_trim, .mid_run,
    .loop_run, .loop_closed, .loop_quick_lock, .loop_chill_cycle, .loop_drop_locks,
    .loop_freeze_fine);
`default_nettype wire

/* verification/test_internal_oscillator_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_internal_oscillator_control;
    import ioc_pkg::*;
    // ==============================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, mb, pat;
    logic        write_protect, in_standby, wake_event, mid_request, loop_request;
    logic        mid_osc_clk, slow_osc_clk, loop_fine_locked, mid_run, mid_div_clk, loop_run;
    logic        loop_closed, loop_quick_lock, loop_chill_cycle, loop_drop_locks;
    logic        loop_freeze_fine, slow_clk_out;
    logic [4:0]  ulp_trim;
    ioc_mid_s    mid_cfg;
    ioc_trim_value_s  trim_value;
    int          n_errors = 0, comparisons = 0, cyc = 0, n;
    ioc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .write_protect, .in_standby, .wake_event, .trim_value, .mid_request, .loop_request,
        .mid_osc_clk, .slow_osc_clk, .loop_fine_locked, .mid_cfg, .ulp_trim, .mid_run,
        .mid_div_clk, .loop_run, .loop_closed, .loop_quick_lock, .loop_chill_cycle,
        .loop_drop_locks, .loop_freeze_fine, .slow_clk_out);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // oscillator clocks and the run ceiling
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        mid_osc_clk <= cyc[1];
        slow_osc_clk <= cyc[2];
        if (cyc == 6000) begin
            n_errors++;
            complete_run();
        end
    end
    // ==============================
    // tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_cnt(input string nm, input int e, input int g);
        comparisons++;
        if (g < e - 1 || g > e + 1) begin
            n_errors++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rc
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // ==============================
    // tests
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {write_protect, in_standby, wake_event, mid_request, loop_request} = '0;
        {loop_fine_locked, presetn} = '0;
        trim_value = {2'h2, 12'ha5c, 5'h13};
        mb = {trim_value.range, 2'h0, trim_value.mid_trim, 16'h0000};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rc("loop_reset", FLOOP_OFFSET, 32'h0000_0080);
        chk("quick_chill", 2'b11, 32'({loop_quick_lock, loop_chill_cycle}));
        rc("ulp_reset", ULP_OSC_OFFSET, 32'(trim_value.ulp_trim));
        rc("mid_reset", MID_OSC_OFFSET, mb | 32'h0000_0380);
        rc("unmapped", 8'h40, 32'h0000_0000);
        chk("no_error", 32'h0000_0000, 32'(pslverr));
        chk("ulp_trim_out", 32'(trim_value.ulp_trim), 32'(ulp_trim));
        chk("mid_trim_out", 32'(trim_value.mid_trim), 32'(mid_cfg.trim));
        chk("mid_range_out", 32'(trim_value.range), 32'(mid_cfg.range));
        done("reset");
        apb(1'b1, ULP_OSC_OFFSET, 32'h0000_000a);
        rc("ulp_trim", ULP_OSC_OFFSET, 32'h0000_000a);
        apb(1'b1, ULP_OSC_OFFSET, 32'h0000_0085);
        apb(1'b1, ULP_OSC_OFFSET, 32'h0000_0002);
        rc("ulp_locked", ULP_OSC_OFFSET, 32'h0000_0085);
        write_protect <= 1'b1;
        apb(1'b1, MID_OSC_OFFSET, 32'h0000_0000);
        write_protect <= 1'b0;
        rc("mid_protected", MID_OSC_OFFSET, mb | 32'h0000_0382);
        done("lock");
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, MID_OSC_OFFSET, mb | 32'({i[0], i[1], 6'h02}));
            mid_request <= i[2];
            in_standby  <= i[3];
            repeat (2) @(posedge pclk);
            chk("mid_run", 32'((!i[0] || i[2]) && (!i[3] || i[1])), 32'(mid_run));
        end
        in_standby  <= 1'b0;
        mid_request <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, MID_OSC_OFFSET, mb | 32'h0000_0002 | (32'(d) << 8));
            n = 0;
            repeat (256) begin
                @(posedge pclk);
                n += int'(mid_div_clk === 1'b1);
            end
            chk_cnt("div_pulses", 64 >> d, n);
        end
        done("mid");
        rc("mid_on", MID_OSC_OFFSET, mb | 32'h0000_0302);
        apb(1'b1, MID_OSC_OFFSET, mb | 32'h0000_0300);
        rc("mid_stopping", MID_OSC_OFFSET, mb | 32'h0000_0302);
        repeat (30) @(posedge pclk);
        rc("mid_off", MID_OSC_OFFSET, mb | 32'h0000_0300);
        chk("mid_off_run", 32'h0000_0000, 32'(mid_run));
        apb(1'b1, MID_OSC_OFFSET, mb | 32'h0000_0302);
        rc("mid_starting", MID_OSC_OFFSET, mb | 32'h0000_0300);
        repeat (30) @(posedge pclk);
        rc("mid_started", MID_OSC_OFFSET, mb | 32'h0000_0302);
        done("enable");
        for (int j = 0; j < 4; j++) begin
            pat = 32'({j[1], j[0], 5'h00, j[0] ~^ j[1], j == 3, 1'b0});
            apb(1'b1, FLOOP_OFFSET, pat);
            rc("loop_readback", FLOOP_OFFSET, pat & 32'(FL_MASK));
            chk("loop_bits", 32'({!j[1], !j[0], j[0] ~^ j[1]}),
                32'({loop_quick_lock, loop_chill_cycle, loop_closed}));
        end
        repeat (10) @(posedge pclk);
        chk("loop_run", 32'h0000_0001, 32'(loop_run));
        rc("status", STATUS_OFFSET, 32'h0000_0007);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, FLOOP_OFFSET, 32'h0000_0002 | (32'(k) << 4));
            in_standby <= 1'b1;
            repeat (4) @(posedge pclk);
            in_standby <= 1'b0;
            wake_event <= 1'b1;
            @(posedge pclk);
            wake_event <= 1'b0;
            n = 0;
            repeat (4) begin
                @(posedge pclk);
                n += int'(loop_drop_locks === 1'b1);
            end
            chk("drop_locks", 32'(k), 32'(n));
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, FLOOP_OFFSET, 32'h0000_0002 | (32'(k) << 3));
            loop_fine_locked <= 1'b1;
            repeat (4) @(posedge pclk);
            chk("freeze_fine", 32'(k), 32'(loop_freeze_fine));
            loop_fine_locked <= 1'b0;
        end
        done("loop");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, CTRL_OFFSET, 32'h0000_0002 | (32'(k) << 2));
            n = 0;
            repeat (64) begin
                @(posedge pclk);
                n += int'(slow_clk_out === 1'b1);
            end
            chk("slow_out", 32'(k), 32'(n > 0));
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b1, ULP_OSC_OFFSET, 32'h0000_000a);
        rc("ulp_unlocked", ULP_OSC_OFFSET, 32'h0000_000a);
        done("slow");
        complete_run();
    end
endmodule : test_internal_oscillator_control
`default_nettype wire
